// ===== dtp_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef DTP_CFG_SVH
`define DTP_CFG_SVH
`define DTP_ADDR_W        3
`define DTP_OFS_CNT_HI    3'h0
`define DTP_OFS_CNT_LO    3'h1
`define DTP_OFS_PRE       3'h2
`define DTP_OFS_CTRL      3'h3
`define DTP_OFS_IRQ_SEL   3'h4
`define DTP_OFS_STATUS    3'h5
`define DTP_CTRL_RST      8'h12
`define DTP_IRQ_SEL_RST   8'h06
`define DTP_B_RUN         7
`define DTP_B_SINGLE      6
`define DTP_B_MODE_A      5
`define DTP_B_MODE_B      4
`define DTP_B_IN_EN       3
`define DTP_B_OUT_MODE    2
`define DTP_B_OUT_LEVEL   1
`define DTP_B_OUT_EN      0
`define DTP_B_TOP_SEL     2
`define DTP_B_A0_SEL      1
`define DTP_TICK_DIV      2'h3
`endif

// ===== dtp_pkg.sv
// types shared by the down timer modules
package dtp_pkg;
  typedef enum logic [1:0] {
    DTP_IN_EVENT,
    DTP_IN_GATED,
    DTP_IN_TRIG,
    DTP_IN_RETRIG
  } dtp_in_mode_e;
endpackage : dtp_pkg

// ===== dtp_tick_if.sv
// internal tick and falling edge events between the edge unit and core
`timescale 1ns/1ps
`default_nettype none
interface dtp_tick_if;
  logic tick;
  logic pin_fall;
  logic pin_level;
  modport src (output tick, output pin_fall, output pin_level);
  modport dst (input tick, input pin_fall, input pin_level);
endinterface : dtp_tick_if
`default_nettype wire

// ===== dtp_edge.sv
// core clock divide-by-four tick and input pin edge detection
`timescale 1ns/1ps
`include "dtp_cfg.svh"
`default_nettype none
module dtp_edge (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   pin_in,
  dtp_tick_if.src     ev
);
  logic [1:0] div_q;
  logic       pin_q;
  logic       tick_q;
  logic       fall_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + 2'h1;
      tick_q <= (div_q == `DTP_TICK_DIV); // see (RULE2)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q  <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      pin_q  <= pin_in;
      fall_q <= pin_q & ~pin_in; // see (RULE4)
    end
  end

  assign ev.tick      = tick_q;
  assign ev.pin_fall  = fall_q;
  assign ev.pin_level = pin_q;
endmodule : dtp_edge
`default_nettype wire

// ===== dtp_timer.sv
// down timer with prescaler: registers, counting, output and interrupt
// Notes on behaviour
// (RULE1) 16-bit counter behind 8-bit prescaler
// (RULE2) clock is pin or core divided by four
// (RULE3) input enable clear ignores mode bits
// (RULE4) mode 00 counts pin falling edges
// (RULE5) mode 01 counts ticks while pin high
// (RULE6) mode 11 starts on run or fall
// (RULE7) mode 10 fall restarts only while running
// (RULE8) output mode 0 toggles each end
// (RULE9) output mode 1 copies level bit
// (RULE10) output disabled holds pin high
// (RULE11) run bit starts and stops counting
// (RULE12) restart resumes held value unless rewritten
// (RULE13) constant written while running loads at end
// (RULE14) single mode stops, clears run, reloads
// (RULE15) continuous mode reloads and keeps counting
// (RULE16) single bit writable anytime with run
// (RULE17) end of count interrupt, two routes
// (RULE18) prescale factor is value plus one
// (RULE19) control resets to 12h, fixed layout
// (RULE20) decrement per rollover, end at zero
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "dtp_cfg.svh"
`default_nettype none
module dtp_timer (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [`DTP_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rdata,
  input  wire logic                   timer_in,
  input  wire logic                   nmi_pin,
  input  wire logic                   external_irq_line_zero,
  output logic                        timer_out,
  output logic                        top_irq,
  output logic                        chan_a0_irq
);
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [15:0] const_q;
  logic [7:0]  pre_const_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  irq_sel_q;
  logic [15:0] cnt_q;
  logic [7:0]  pre_q;
  logic        new_const_q;
  logic        out_q;
  logic        eoc_q;
  logic        top_q;
  logic        a0_q;
  logic [7:0]  rdata_q;
  logic        step;
  logic        roll;
  logic        eoc;
  logic        restart;
  logic        run_bit;
  logic        input_section_enable;
  dtp_pkg::dtp_in_mode_e mode;

  dtp_tick_if ev ();

  // reset released through two flops so deassertion is clean
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  dtp_edge u_edge (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .pin_in (timer_in),
    .ev     (ev)
  );

  assign run_bit              = ctrl_q[`DTP_B_RUN];
  assign input_section_enable = ctrl_q[`DTP_B_IN_EN];
  assign mode = dtp_pkg::dtp_in_mode_e'({ctrl_q[`DTP_B_MODE_A],
                                         ctrl_q[`DTP_B_MODE_B]});

  // clock source and count enable per input mode
  always_comb begin
    step    = 1'b0;
    restart = 1'b0;
    if (run_bit) begin // see (RULE11)
      if (!input_section_enable) begin
        step = ev.tick; // see (RULE3)
      end else begin
        case (mode)
          dtp_pkg::DTP_IN_EVENT: begin
            step = ev.pin_fall; // see (RULE4)
          end
          dtp_pkg::DTP_IN_GATED: begin
            step = ev.tick & ev.pin_level; // see (RULE5)
          end
          dtp_pkg::DTP_IN_TRIG: begin
            step    = ev.tick;
            restart = ev.pin_fall; // see (RULE7)
          end
          default: begin
            step = ev.tick; // see (RULE6)
          end
        endcase
      end
    end
  end

  assign roll = step && (pre_q == 8'h00); // see (RULE18)
  assign eoc  = roll && (cnt_q == 16'h0000) && !restart; // see (RULE20)

  // counter constant and constant-written flag, set by a write to either count byte, cleared at end of count or restart
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      const_q     <= 16'h0000;
      new_const_q <= 1'b0;
    end else begin
      if (wr_stb && addr == `DTP_OFS_CNT_HI) begin
        const_q[15:8] <= wdata;
      end
      if (wr_stb && addr == `DTP_OFS_CNT_LO) begin
        const_q[7:0] <= wdata;
      end
      if (wr_stb && (addr == `DTP_OFS_CNT_HI ||
                     addr == `DTP_OFS_CNT_LO)) begin
        new_const_q <= 1'b1; // see (RULE12)
      end else if (eoc || restart) begin
        new_const_q <= 1'b0;
      end
    end
  end

  // prescaler and 16-bit down counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      pre_q <= 8'h00;
    end else if (!run_bit && new_const_q) begin
      cnt_q <= const_q; // see (RULE12)
      pre_q <= pre_const_q;
    end else if (restart) begin
      cnt_q <= const_q; // see (RULE7)
      pre_q <= pre_const_q;
    end else if (step) begin
      if (pre_q == 8'h00) begin
        pre_q <= pre_const_q; // see (RULE1)
        if (cnt_q == 16'h0000) begin
          cnt_q <= const_q; // see (RULE13) (RULE14) (RULE15)
        end else begin
          cnt_q <= cnt_q - 16'h0001; // see (RULE20)
        end
      end else begin
        pre_q <= pre_q - 8'h01;
      end
    end
  end

  // control, prescaler and interrupt route registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= `DTP_CTRL_RST; // see (RULE19)
      pre_const_q <= 8'h00;
      irq_sel_q   <= `DTP_IRQ_SEL_RST;
    end else begin
      if (wr_stb && addr == `DTP_OFS_PRE) begin
        pre_const_q <= wdata;
      end
      if (wr_stb && addr == `DTP_OFS_IRQ_SEL) begin
        irq_sel_q <= wdata;
      end
      if (wr_stb && addr == `DTP_OFS_CTRL) begin
        ctrl_q <= wdata; // see (RULE16)
        if (eoc && ctrl_q[`DTP_B_SINGLE] && wdata[`DTP_B_RUN]) begin
          ctrl_q[`DTP_B_RUN] <= 1'b1;
        end
      end else if (input_section_enable && ev.pin_fall &&
                   mode == dtp_pkg::DTP_IN_RETRIG) begin
        // trigger start wins over a single-mode stop in the same cycle
        ctrl_q[`DTP_B_RUN] <= 1'b1; // see (RULE6)
      end else if (eoc && ctrl_q[`DTP_B_SINGLE]) begin
        ctrl_q[`DTP_B_RUN] <= 1'b0; // see (RULE14)
      end
    end
  end

  // output pin, high whenever the drive is off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b1;
    end else if (!ctrl_q[`DTP_B_OUT_EN]) begin
      out_q <= 1'b1; // see (RULE10)
    end else if (eoc) begin
      if (ctrl_q[`DTP_B_OUT_MODE]) begin
        out_q <= ctrl_q[`DTP_B_OUT_LEVEL]; // see (RULE9)
      end else begin
        out_q <= ~out_q; // see (RULE8)
      end
    end
  end

  // end-of-count pulse routed to top level or channel a0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
      top_q <= 1'b0;
      a0_q  <= 1'b0;
    end else begin
      eoc_q <= eoc;
      top_q <= irq_sel_q[`DTP_B_TOP_SEL] ? nmi_pin : eoc; // see (RULE17)
      a0_q  <= irq_sel_q[`DTP_B_A0_SEL] ? eoc
                                        : external_irq_line_zero;
    end
  end

  // read port, data valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `DTP_OFS_CNT_HI) begin
        rdata_q <= cnt_q[15:8];
      end else if (addr == `DTP_OFS_CNT_LO) begin
        rdata_q <= cnt_q[7:0];
      end else if (addr == `DTP_OFS_PRE) begin
        rdata_q <= pre_const_q;
      end else if (addr == `DTP_OFS_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (addr == `DTP_OFS_IRQ_SEL) begin
        rdata_q <= irq_sel_q;
      end else if (addr == `DTP_OFS_STATUS) begin
        rdata_q <= {6'h00, new_const_q, eoc_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata       = rdata_q;
  assign timer_out   = out_q;
  assign top_irq     = top_q;
  assign chan_a0_irq = a0_q;
endmodule : dtp_timer
`default_nettype wire

// ===== dtp_timer_monitor.sv
// port checker for the down timer
`timescale 1ns/1ps
`include "dtp_cfg.svh"
`default_nettype none
module dtp_timer_monitor (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       nmi_pin,
  input wire logic       external_irq_line_zero,
  input wire logic       timer_out,
  input wire logic       top_irq,
  input wire logic       chan_a0_irq
);
  logic [7:0] c_q;
  logic [7:0] r_q;
  logic [3:0] u_q;
  logic [1:0] s_q;
  // margin past the two-flop reset release inside
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) u_q <= 4'h0;
    else u_q <= {u_q[2:0], 1'b1};
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) {c_q, r_q} <= {`DTP_CTRL_RST, `DTP_IRQ_SEL_RST};
    else if (wr_stb && addr == `DTP_OFS_CTRL) c_q <= wdata;
    else if (wr_stb && addr == `DTP_OFS_IRQ_SEL) r_q <= wdata;
  // control age: registered pin needs two cycles to follow a write
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) s_q <= 2'h0;
    else if (wr_stb && addr == `DTP_OFS_CTRL) s_q <= 2'h0;
    else if (s_q != 2'h3) s_q <= s_q + 2'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!u_q[3]);
  chk_ctrl_readback: assert property (
    rd_stb && addr == `DTP_OFS_CTRL |=> rdata[6:0] == $past(c_q[6:0]))
    else $error("control readback differs");
  chk_read_idle: assert property (
    !$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_out_high: assert property (
    !c_q[0] && s_q == 2'h3 |-> timer_out)
    else $error("disabled output not high");
  chk_eoc_toggle: assert property (
    c_q[0] && !c_q[2] && s_q == 2'h3 && r_q[1] && $stable(r_q) && chan_a0_irq
    |-> ##[0:1] $changed(timer_out))
    else $error("output did not toggle at end of count");
  chk_level_copy: assert property (
    c_q[0] && c_q[2] && s_q == 2'h3 && $changed(timer_out)
    |-> timer_out == $past(c_q[1]))
    else $error("output level differs from level bit");
  chk_top_nmi: assert property (
    r_q[2] && $stable(r_q) |-> top_irq == $past(nmi_pin))
    else $error("top interrupt not following pin");
  chk_a0_ext: assert property (
    !r_q[1] && $stable(r_q) |-> chan_a0_irq == $past(external_irq_line_zero))
    else $error("a0 interrupt not following pin");
  chk_top_eoc: assert property (
    !r_q[2] && r_q[1] && $stable(r_q) |-> top_irq == chan_a0_irq)
    else $error("top interrupt not end of count");
endmodule : dtp_timer_monitor
bind dtp_timer dtp_timer_monitor i_mon (.ref_clk(ref_clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .nmi_pin(nmi_pin), .timer_out(timer_out),
  .external_irq_line_zero(external_irq_line_zero), .top_irq(top_irq),
  .chan_a0_irq(chan_a0_irq));
`default_nettype wire

// ===== dtp_pin_src.sv
// far-side model driving the timer input pin
`timescale 1ns/1ps
`default_nettype none
module dtp_pin_src (
  input  wire logic clk,
  output var logic  pin
);
  initial pin = 1'b1;
  // falls kept six clocks apart, above the edge spacing floor
  task automatic falls(input int n);
    repeat (n) begin
      @(posedge clk) pin <= 1'b0;
      repeat (2) @(posedge clk);
      pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : falls
  // pin held low for a stretch, then back to its idle high
  task automatic hold_low(input int n);
    @(posedge clk) pin <= 1'b0;
    repeat (n) @(posedge clk);
    pin <= 1'b1;
  endtask : hold_low
endmodule : dtp_pin_src
`default_nettype wire

// ===== dtp_timer_tb.sv
// self-checking bench for the down timer
`timescale 1ns/1ps
`include "dtp_cfg.svh"
`default_nettype none
module dtp_timer_tb;
  logic       ref_clk, rstn, wr_stb, rd_stb, nmi_pin, ext_irq, rd_d;
  logic       timer_in, timer_out, top_irq, chan_a0_irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, pv, cv;
  logic [7:0] exp_q[$];
  logic [7:0] ctl_t[3] = '{8'h81, 8'hb1, 8'h85};
  int         err_total, n_tests, n_eoc, gap, n0;
  int         seed = 32'hc922fd06;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  dtp_timer i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .timer_in(timer_in), .nmi_pin(nmi_pin), .external_irq_line_zero(ext_irq),
    .timer_out(timer_out), .top_irq(top_irq), .chan_a0_irq(chan_a0_irq));
  dtp_pin_src i_pin (.clk(ref_clk), .pin(timer_in));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask : rd
  // constants written while stopped load at once
  task automatic setup(input logic [7:0] p, c, k);
    wr(`DTP_OFS_CTRL, 8'h00);
    wr(`DTP_OFS_CNT_HI, 8'h00);
    wr(`DTP_OFS_CNT_LO, c);
    wr(`DTP_OFS_PRE, p);
    wr(`DTP_OFS_CTRL, k);
  endtask : setup
  task automatic wait_eoc(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (chan_a0_irq !== 1'b1 && c < 9000);
  endtask : wait_eoc
  always @(posedge ref_clk) begin
    rd_d <= rd_stb;
    {nmi_pin, ext_irq} <= 2'($random(seed));
    if (chan_a0_irq === 1'b1) n_eoc <= n_eoc + 1;
    if (rd_d) check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
  end
  initial begin
    {rstn, wr_stb, rd_stb, nmi_pin, ext_irq, rd_d, addr, wdata} = '0;
    {err_total, n_tests, n_eoc} = '0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`DTP_OFS_CTRL, `DTP_CTRL_RST);
    rd(`DTP_OFS_IRQ_SEL, `DTP_IRQ_SEL_RST);
    rd(3'h7, 8'h00);
    for (int i = 0; i < 3; i++) begin
      pv = 8'($random(seed) & 3);
      cv = 8'($random(seed) & 3);
      setup(pv, cv, ctl_t[i]);
      wait_eoc(gap);
      wait_eoc(gap);
      n0 = 4 * (pv + 1) * (cv + 1);
      check("eoc gap", 16'(gap), 16'(n0));
    end
    wr(`DTP_OFS_IRQ_SEL, 8'h02);
    wait_eoc(gap);
    wait_eoc(gap);
    setup(8'h00, 8'h01, 8'hc1);
    wait_eoc(gap);
    @(posedge ref_clk);
    n0 = n_eoc;
    repeat (100) @(posedge ref_clk);
    check("single eocs", 16'(n_eoc - n0), 16'h0000);
    rd(`DTP_OFS_CTRL, 8'h41);
    setup(8'h00, 8'h02, 8'h88);
    n0 = n_eoc;
    i_pin.falls(6);
    repeat (8) @(posedge ref_clk);
    check("event eocs", 16'(n_eoc - n0), 16'h0002);
    setup(8'h00, 8'h01, 8'h99);
    wait_eoc(gap);
    wait_eoc(gap);
    check("gated gap", 16'(gap), 16'h0008);
    @(posedge ref_clk);
    n0 = n_eoc;
    i_pin.hold_low(40);
    check("gated eocs", 16'(n_eoc - n0), 16'h0000);
    setup(8'h00, 8'h03, 8'ha9);
    wait_eoc(gap);
    @(posedge ref_clk);
    n0 = n_eoc;
    i_pin.falls(8);
    check("trig eocs", 16'(n_eoc - n0), 16'h0000);
    setup(8'h00, 8'h03, 8'h38);
    i_pin.falls(1);
    rd(`DTP_OFS_CTRL, 8'hb8);
    wr(`DTP_OFS_IRQ_SEL, 8'h04);
    repeat (20) @(posedge ref_clk);
    end_sim();
  end
  initial begin
    #200us;
    err_total++;
    end_sim();
  end
endmodule : dtp_timer_tb
`default_nettype wire
